// File: rtl/pms_pkg.sv
package pms_pkg;

   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFF_PWR_CTRL = 4'h0;  // power_control_register
   localparam logic [3:0] OFF_PLL_CTRL = 4'h1;  // pll_control_register
   localparam logic [3:0] OFF_STATUS   = 4'h2;  // power mode, one-hot
   localparam logic [3:0] OFF_IRQ_STAT = 4'h3;  // sticky event bits
   localparam logic [3:0] OFF_IRQ_MASK = 4'h4;  // event mask

   // Power control register fields
   localparam int PC_IDLE     = 0;
   localparam int PC_PDOWN    = 1;
   localparam int PC_SER_WAKE = 2;  // serial_wake_enable_bit
   localparam int PC_EXT_WAKE = 3;  // ext_irq0_wake_enable_bit

   // PLL control register fields
   localparam int PL_OSCILLATOR_POWERDOWN_BIT = 4;    // oscillator_powerdown_bit
   localparam int PL_LOCK   = 6;

   // Interrupt event fields
   localparam int EV_WAKE   = 0;
   localparam int EV_LOCK   = 1;
   localparam int EV_IDLEX  = 2;

   // Reset values
   localparam logic [7:0] PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] PLL_CTRL_RST = 8'h00;
   localparam logic [7:0] MASK_RST     = 8'h00;

   // Supply thresholds in millivolts
   localparam int unsigned VDD_ON_MV  = 2450;
   localparam int unsigned VDD_OFF_MV = 1000;

   // Timing figures and derived counts at 200 MHz
   localparam int unsigned CLK_MHZ     = 200;
   localparam int unsigned POR_MS      = 128;
   localparam int unsigned PLL_LOCK_MS = 1;
   localparam int unsigned XTAL_MS     = 150;
   localparam int unsigned POR_CYC     = POR_MS * 1000 * CLK_MHZ;
   localparam int unsigned PLL_CYC     = PLL_LOCK_MS * 1000 * CLK_MHZ;
   localparam int unsigned XTAL_CYC    = XTAL_MS * 1000 * CLK_MHZ;

   // Power modes, one-hot
   typedef enum logic [3:0] {
      PMS_RESET  = 4'b0001,
      PMS_NORMAL = 4'b0010,
      PMS_IDLE   = 4'b0100,
      PMS_PDOWN  = 4'b1000
   } pms_mode_t;

   // Clock and pin controls toward the chip
   typedef struct packed {
      logic osc_en;
      logic pll_en;
      logic core_clk_en;
      logic periph_clk_en;
      logic tic_clk_en;
      logic port_hold;
      logic dac_oe;
      logic ale_force;
      logic prog_store_strobe_force;
      logic strobe_level;
   } pms_ctl_t;

   // Wake sources from core and peripherals
   typedef struct packed {
      logic any_irq;
      logic tic_irq;
      logic tic_en;
      logic serial_irq;
      logic serial_irq_en;
      logic ext0_irq;
      logic ext0_irq_en;
   } pms_wake_t;

endpackage : pms_pkg

// File: rtl/pms_sequencer.sv
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Hold reset below 2.45 V, then 128 ms
// - On falling supply hold reset below 1 V
// - Bit 0 enters Idle, bit 1 Power-Down
// - Idle: oscillator and peripherals run, core halts
// - Idle: state kept, strobes driven high
// - Enabled interrupt or reset ends Idle
// - Power-Down stops PLL, core; oscillator per bit
// - Power-Down: only interval counter may run
// - Power-Down: ports held, DAC off, strobes low
// - Reset pin returns to Normal with defaults
// - Power cycle restarts after 128 ms
// - Counter wakes only if oscillator on, enabled
// - Serial irq wakes only if enable set
// - External irq 0 wakes only if enable set
// - Return resumes after the entering instruction
// - Lock reported on bit 6 after 1 ms
// - Stopped oscillator adds 150 ms before lock
module pms_sequencer #(
   parameter int unsigned POR_CYCLES  = pms_pkg::POR_CYC,
   parameter int unsigned PLL_CYCLES  = pms_pkg::PLL_CYC,
   parameter int unsigned XTAL_CYCLES = pms_pkg::XTAL_CYC
) (
   input  wire logic                      clock_i,       // 200 MHz clock
   input  wire logic                      sys_rst_i,     // Async reset, high
   input  wire logic [15:0]               vdd_mv_i,      // Digital supply, millivolts
   input  wire logic                      reset_pin_i,   // External reset pin, high
   input  wire pms_pkg::pms_wake_t        wake_i,        // Wake sources, pin domain
   input  wire logic [pms_pkg::ADDR_W-1:0] addr_i,       // Register address
   input  wire logic [pms_pkg::DATA_W-1:0] wdata_i,      // Write data
   input  wire logic                      wr_i,          // Write strobe
   input  wire logic                      rd_i,          // Read strobe
   output logic [pms_pkg::DATA_W-1:0]     rdata_o,       // Read data, next cycle
   output logic                           chip_rst_o,    // Chip reset, high
   output pms_pkg::pms_ctl_t              ctl_o,         // Clock and pin controls
   output logic                           wake_vector_o, // Pulse: service wake irq
   output logic                           irq_o          // Level interrupt
);

   // Whole module state
   typedef struct packed {
      logic [1:0]             rst_sy;
      logic [1:0]             vdd_ok_sy;
      logic [1:0]             vdd_hi_sy;
      logic [6:0]             wk_s1;
      logic [6:0]             wk_s2;
      logic                   supply_on;
      logic [31:0]            por_cnt;
      logic [31:0]            lock_cnt;
      logic                   osc_was_off;
      pms_pkg::pms_mode_t     mode;
      logic [7:0]             pwr_ctrl;
      logic [7:0]             pll_ctrl;
      logic [7:0]             irq_stat;
      logic [7:0]             irq_mask;
      logic [7:0]             rdata;
      logic                   chip_rst;
      pms_pkg::pms_ctl_t      ctl;
      logic                   wake_vec;
      logic                   irq;
   } pms_state_t;

   pms_state_t st_r;
   pms_state_t st_nxt;
   pms_pkg::pms_wake_t wk;
   logic       vdd_above_on;
   logic       vdd_above_off;
   logic       pdown_wake;
   logic       lock_done;
   logic [7:0] stat_word;

   // Controls for a given mode
   function automatic pms_pkg::pms_ctl_t mode_ctl(input pms_pkg::pms_mode_t m, input logic oscillator_powerdown_bit,
                                                  input logic tic_en);
      pms_pkg::pms_ctl_t c;
      c = '0;
      c.osc_en        = 1'b1;
      c.pll_en        = 1'b1;
      c.core_clk_en   = 1'b1;
      c.periph_clk_en = 1'b1;
      c.tic_clk_en    = tic_en;
      c.dac_oe        = 1'b1;
      unique case (m)
         pms_pkg::PMS_RESET:
         begin
            c.core_clk_en = 1'b0;
         end
         pms_pkg::PMS_NORMAL:
         begin
            c.core_clk_en = 1'b1;
         end
         pms_pkg::PMS_IDLE:
         begin
            c.core_clk_en             = 1'b0;
            c.port_hold               = 1'b1;
            c.ale_force               = 1'b1;
            c.prog_store_strobe_force = 1'b1;
            c.strobe_level            = 1'b1;
         end
         pms_pkg::PMS_PDOWN:
         begin
            c.osc_en                  = ~oscillator_powerdown_bit;
            c.pll_en                  = 1'b0;
            c.core_clk_en             = 1'b0;
            c.periph_clk_en           = 1'b0;
            c.tic_clk_en              = tic_en & ~oscillator_powerdown_bit;
            c.port_hold               = 1'b1;
            c.dac_oe                  = 1'b0;
            c.ale_force               = 1'b1;
            c.prog_store_strobe_force = 1'b1;
            c.strobe_level            = 1'b0;
         end
         default:
         begin
            c.core_clk_en = 1'b0;
         end
      endcase
      return c;
   endfunction : mode_ctl

   // Synchronised wake sources and supply compares
   assign wk            = pms_pkg::pms_wake_t'(st_r.wk_s2);
   assign vdd_above_on  = (32'(vdd_mv_i) > pms_pkg::VDD_ON_MV);
   assign vdd_above_off = (32'(vdd_mv_i) >= pms_pkg::VDD_OFF_MV);
   assign pdown_wake    = (wk.tic_irq & wk.tic_en & ~st_r.pll_ctrl[pms_pkg::PL_OSCILLATOR_POWERDOWN_BIT])
                        | (wk.serial_irq & wk.serial_irq_en & st_r.pwr_ctrl[pms_pkg::PC_SER_WAKE])
                        | (wk.ext0_irq & wk.ext0_irq_en & st_r.pwr_ctrl[pms_pkg::PC_EXT_WAKE]);
   assign lock_done     = (st_r.lock_cnt == 32'h0000_0000);
   assign stat_word     = {4'h0, st_r.mode};

   // Next-state logic
   always_comb
   begin
      logic [7:0] ev;
      ev     = 8'h00;
      st_nxt = st_r;
      st_nxt.rst_sy    = {st_r.rst_sy[0], reset_pin_i};
      st_nxt.vdd_hi_sy = {st_r.vdd_hi_sy[0], vdd_above_on};
      st_nxt.vdd_ok_sy = {st_r.vdd_ok_sy[0], vdd_above_off};
      st_nxt.wk_s1     = wake_i;
      st_nxt.wk_s2     = st_r.wk_s1;
      st_nxt.wake_vec  = 1'b0;

      // Supply hysteresis: on above 2.45 V, off only below 1 V
      if (st_r.vdd_hi_sy[1])
         st_nxt.supply_on = 1'b1;
      else if (!st_r.vdd_ok_sy[1])
         st_nxt.supply_on = 1'b0;

      // Lock countdown after wake
      if (!lock_done && st_r.mode != pms_pkg::PMS_PDOWN)
         st_nxt.lock_cnt = st_r.lock_cnt - 32'h0000_0001;
      if (st_r.lock_cnt == 32'h0000_0001)
      begin
         st_nxt.pll_ctrl[pms_pkg::PL_LOCK] = 1'b1;
         ev[pms_pkg::EV_LOCK] = 1'b1;
      end

      // Register writes
      if (wr_i)
      begin
         unique case (addr_i)
            pms_pkg::OFF_PWR_CTRL: st_nxt.pwr_ctrl = wdata_i;
            pms_pkg::OFF_PLL_CTRL: st_nxt.pll_ctrl = {st_r.pll_ctrl[7], st_nxt.pll_ctrl[6], wdata_i[5:0]};
            pms_pkg::OFF_IRQ_MASK: st_nxt.irq_mask = wdata_i;
            pms_pkg::OFF_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat & ~wdata_i;
            default: ;
         endcase
      end

      // Mode sequencing
      unique case (st_r.mode)
         pms_pkg::PMS_RESET:
         begin
            if (st_r.supply_on && !st_r.rst_sy[1])
            begin
               if (st_r.por_cnt >= 32'(POR_CYCLES) - 32'h0000_0001)
                  st_nxt.mode = pms_pkg::PMS_NORMAL;
               else
                  st_nxt.por_cnt = st_r.por_cnt + 32'h0000_0001;
            end
         end
         pms_pkg::PMS_NORMAL:
         begin
            if (st_r.pwr_ctrl[pms_pkg::PC_PDOWN])
            begin
               st_nxt.mode        = pms_pkg::PMS_PDOWN;
               st_nxt.osc_was_off = st_r.pll_ctrl[pms_pkg::PL_OSCILLATOR_POWERDOWN_BIT];
               st_nxt.pll_ctrl[pms_pkg::PL_LOCK] = 1'b0;
            end
            else if (st_r.pwr_ctrl[pms_pkg::PC_IDLE])
               st_nxt.mode = pms_pkg::PMS_IDLE;
         end
         pms_pkg::PMS_IDLE:
         begin
            if (wk.any_irq)
            begin
               st_nxt.mode = pms_pkg::PMS_NORMAL;
               st_nxt.pwr_ctrl[pms_pkg::PC_IDLE] = 1'b0;
               ev[pms_pkg::EV_IDLEX] = 1'b1;
            end
         end
         pms_pkg::PMS_PDOWN:
         begin
            if (pdown_wake)
            begin
               st_nxt.mode     = pms_pkg::PMS_NORMAL;
               st_nxt.wake_vec = 1'b1;
               st_nxt.pwr_ctrl[pms_pkg::PC_IDLE]  = 1'b0;
               st_nxt.pwr_ctrl[pms_pkg::PC_PDOWN] = 1'b0;
               st_nxt.lock_cnt = 32'(PLL_CYCLES) + (st_r.osc_was_off ? 32'(XTAL_CYCLES) : 32'h0);
               ev[pms_pkg::EV_WAKE] = 1'b1;
            end
         end
         default: st_nxt.mode = pms_pkg::PMS_RESET;
      endcase

      // Pin reset or supply loss: defaults; supply loss restarts timer, pin reset skips it
      if (st_r.rst_sy[1] || !st_r.supply_on)
      begin
         st_nxt.mode     = pms_pkg::PMS_RESET;
         st_nxt.por_cnt  = st_r.rst_sy[1] && st_r.supply_on ? 32'(POR_CYCLES) : 32'h0;
         st_nxt.pwr_ctrl = pms_pkg::PWR_CTRL_RST;
         st_nxt.pll_ctrl = pms_pkg::PLL_CTRL_RST;
         st_nxt.irq_mask = pms_pkg::MASK_RST;
         st_nxt.irq_stat = 8'h00;
         st_nxt.lock_cnt = 32'h0;
         ev              = 8'h00;
      end
      else if (st_r.mode == pms_pkg::PMS_RESET && st_nxt.mode == pms_pkg::PMS_NORMAL)
         st_nxt.pll_ctrl[pms_pkg::PL_LOCK] = 1'b1;

      // Events set over clears
      st_nxt.irq_stat = st_nxt.irq_stat | ev;

      // Read data, one cycle later
      st_nxt.rdata = 8'h00;
      if (rd_i)
      begin
         unique case (addr_i)
            pms_pkg::OFF_PWR_CTRL: st_nxt.rdata = st_r.pwr_ctrl;
            pms_pkg::OFF_PLL_CTRL: st_nxt.rdata = st_r.pll_ctrl;
            pms_pkg::OFF_STATUS:   st_nxt.rdata = stat_word;
            pms_pkg::OFF_IRQ_STAT: st_nxt.rdata = st_r.irq_stat;
            pms_pkg::OFF_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
            default:               st_nxt.rdata = 8'h00;
         endcase
      end

      // Registered outputs
      st_nxt.chip_rst = (st_nxt.mode == pms_pkg::PMS_RESET);
      st_nxt.ctl      = mode_ctl(st_nxt.mode, st_nxt.pll_ctrl[pms_pkg::PL_OSCILLATOR_POWERDOWN_BIT], wk.tic_en);
      st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   // State register
   always_ff @(posedge clock_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r          <= '0;
         st_r.mode     <= pms_pkg::PMS_RESET;
         st_r.chip_rst <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign rdata_o       = st_r.rdata;
   assign chip_rst_o    = st_r.chip_rst;
   assign ctl_o         = st_r.ctl;
   assign wake_vector_o = st_r.wake_vec;
   assign irq_o         = st_r.irq;

endmodule : pms_sequencer
`default_nettype wire

// File: tb/pms_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pms_sequencer_sva #(
   parameter int unsigned POR_CYCLES = 20
) (
   input wire logic               clock_i,      // Clock
   input wire logic               sys_rst_i,    // Reset
   input wire logic [15:0]        vdd_mv_i,     // Supply
   input wire logic               reset_pin_i,  // Reset pin
   input wire pms_pkg::pms_wake_t wake_i,       // Wake sources
   input wire logic [3:0]         addr_i,       // Address
   input wire logic [7:0]         wdata_i,      // Write data
   input wire logic               wr_i,         // Write strobe
   input wire logic               chip_rst_o,   // Chip reset
   input wire pms_pkg::pms_ctl_t  ctl_o,        // Controls
   input wire logic               wake_vector_o // Wake pulse
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic [31:0] good_r;
   logic        por_r;
   // Mode as seen from the clock controls
   wire logic   run_w = !chip_rst_o && ctl_o.core_clk_en;
   wire logic   idle_w = !chip_rst_o && !ctl_o.core_clk_en && ctl_o.periph_clk_en;
   wire logic   pd_w = !chip_rst_o && !ctl_o.core_clk_en && !ctl_o.periph_clk_en;
   wire logic   pc_wr_w = wr_i && addr_i == pms_pkg::OFF_PWR_CTRL && run_w;
   // Supply-good run length; flag for a supply-driven reset
   always_ff @(posedge clock_i or posedge sys_rst_i)
      if (sys_rst_i)
      begin
         good_r <= 32'h0;
         por_r <= 1'b1;
      end
      else
      begin
         good_r <= (vdd_mv_i > pms_pkg::VDD_ON_MV) ? good_r + 32'h1 : 32'h0;
         por_r <= (vdd_mv_i < pms_pkg::VDD_OFF_MV) || (por_r && chip_rst_o);
      end
   property p_por_wait; $fell(chip_rst_o) && por_r |-> good_r >= POR_CYCLES; endproperty
   a_por_wait: assert property (p_por_wait) else $error("early release");
   property p_low_hold; (vdd_mv_i < pms_pkg::VDD_OFF_MV)[*6] |-> chip_rst_o; endproperty
   a_low_hold: assert property (p_low_hold) else $error("no reset at low supply");
   property p_enter_pd; pc_wr_w && wdata_i[1] |-> ##[1:3] pd_w; endproperty
   a_enter_pd: assert property (p_enter_pd) else $error("no power-down");
   property p_idle_ctl; idle_w |-> ctl_o.osc_en && ctl_o.ale_force && ctl_o.prog_store_strobe_force && ctl_o.strobe_level;
   endproperty
   a_idle_ctl: assert property (p_idle_ctl) else $error("idle controls");
   property p_idle_exit; idle_w && wake_i.any_irq |-> ##[1:6] run_w; endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
   property p_pd_ctl; pd_w |-> !ctl_o.pll_en && !ctl_o.dac_oe && ctl_o.port_hold && !ctl_o.strobe_level; endproperty
   a_pd_ctl: assert property (p_pd_ctl) else $error("power-down controls");
   property p_pin_hold; reset_pin_i[*5] |-> chip_rst_o; endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin reset ignored");
   property p_resume; wake_vector_o |-> $past(pd_w); endproperty
   a_resume: assert property (p_resume) else $error("stray wake pulse");
endmodule : pms_sequencer_sva
bind pms_sequencer pms_sequencer_sva #(.POR_CYCLES(POR_CYCLES)) i_pms_sequencer_sva (.clock_i(clock_i),
   .sys_rst_i(sys_rst_i), .vdd_mv_i(vdd_mv_i), .reset_pin_i(reset_pin_i), .wake_i(wake_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .chip_rst_o(chip_rst_o), .ctl_o(ctl_o), .wake_vector_o(wake_vector_o));
`default_nettype wire

// File: tb/pms_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pms_core_model (
   input  wire logic               clock_i,   // Clock
   input  wire logic               sys_rst_i, // Reset
   input  wire pms_pkg::pms_ctl_t  ctl_i,     // Sequencer controls
   input  wire logic [2:0]         fire_i,    // Raise tic, serial, ext0
   input  wire logic [2:0]         en_i,      // Interrupt enables
   output wire pms_pkg::pms_wake_t wake_o     // Interrupt levels
);
   logic [2:0] pend_r;
   // Timer fires only while clocked; pending cleared once the core runs
   always_ff @(posedge clock_i or posedge sys_rst_i)
      if (sys_rst_i)
         pend_r <= 3'h0;
      else
         pend_r <= (pend_r | (fire_i & {2'b11, ctl_i.tic_clk_en})) & {3{!ctl_i.core_clk_en}};
   // Levels toward the sequencer
   assign wake_o = {|(pend_r & en_i), pend_r[0], en_i[0], pend_r[1], en_i[1], pend_r[2], en_i[2]};
endmodule : pms_core_model
`default_nettype wire

// File: tb/test_pms_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_pms_sequencer;
   localparam int      POR = 20;
   localparam int      PLL = 10;
   localparam int      XTAL = 30;
   logic               clock_i = 1'b0, sys_rst_i = 1'b1, reset_pin_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [15:0]        vdd_mv_i = 16'h0000;
   logic [3:0]         addr_i = 4'h0;
   logic [7:0]         wdata_i = 8'h00, rdata_o;
   logic [2:0]         fire = 3'h0, en = 3'h7;
   logic               chip_rst_o, wake_vector_o, irq_o;
   pms_pkg::pms_ctl_t  ctl_o;
   pms_pkg::pms_wake_t wake_w;
   int                 failures = 0, comparisons = 0, cyc = 0, wakes = 0;
   // Power-down cases: control value, oscillator off, source; first three wake
   logic [7:0]         pc_t [6] = '{8'h02, 8'h06, 8'h0b, 8'h02, 8'h02, 8'h02};
   logic [5:0]         osc_t = 6'b001010;
   int                 src_t [6] = '{0, 1, 2, 0, 1, 2};

   pms_sequencer #(.POR_CYCLES(POR), .PLL_CYCLES(PLL), .XTAL_CYCLES(XTAL)) i_pms_sequencer (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .vdd_mv_i(vdd_mv_i), .reset_pin_i(reset_pin_i), .wake_i(wake_w), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chip_rst_o(chip_rst_o), .ctl_o(ctl_o),
      .wake_vector_o(wake_vector_o), .irq_o(irq_o));
   pms_core_model i_pms_core_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ctl_i(ctl_o), .fire_i(fire),
      .en_i(en), .wake_o(wake_w));

   initial forever #2.5 clock_i = ~clock_i;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(posedge clock_i);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
      @(posedge clock_i);
   endtask : rd

   task automatic until_rst(input logic lvl, output int c);
      c = 0;
      while (chip_rst_o !== lvl && c < 300)
      begin
         @(posedge clock_i);
         c++;
      end
   endtask : until_rst

   // Software wait for the lock bit, as before timing-sensitive work
   task automatic poll_lock(input int lim);
      logic [7:0] d;
      int         c;
      c = 2;
      rd(pms_pkg::OFF_PLL_CTRL, d);
      check(d & 8'h40, 8'h00);
      while (d[6] !== 1'b1 && c < 400)
      begin
         rd(pms_pkg::OFF_PLL_CTRL, d);
         c += 2;
      end
      check(8'(c >= lim && c <= lim + 16), 8'h01);
   endtask : poll_lock

   task automatic wrap_up;
      $display("comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // Cycle limit and wake pulse count
   always @(posedge clock_i)
   begin
      cyc++;
      wakes += int'(wake_vector_o === 1'b1);
      if (cyc == 4000)
      begin
         failures++;
         wrap_up();
      end
   end

   initial
   begin
      int         n, w;
      logic [7:0] rv;
      rv = 8'($urandom(12));
      repeat (16) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      vdd_mv_i <= 16'(pms_pkg::VDD_ON_MV + 50 + $urandom % 1000);
      until_rst(1'b0, n);
      check(8'(n >= POR && n <= POR + 8), 8'h01);
      wr(4'h5, 8'hff);
      for (int a = 4; a < 6; a++)
      begin
         rd(4'(a), rv);
         check(rv, 8'h00);
      end
      $display("power-up done");
      // Idle entry, exit on a serial interrupt, then its event bit
      wr(pms_pkg::OFF_PWR_CTRL, 8'h01);
      rd(pms_pkg::OFF_STATUS, rv);
      check(rv, 8'h04);
      check(8'({ctl_o.osc_en, ctl_o.periph_clk_en, ctl_o.core_clk_en}), 8'h06);
      check(8'({ctl_o.port_hold, ctl_o.ale_force, ctl_o.prog_store_strobe_force, ctl_o.strobe_level}), 8'h0f);
      fire <= 3'h2;
      @(posedge clock_i);
      fire <= 3'h0;
      repeat (8) @(posedge clock_i);
      rd(pms_pkg::OFF_PWR_CTRL, rv);
      check(rv, 8'h00);
      rd(pms_pkg::OFF_IRQ_STAT, rv);
      check(rv & 8'h04, 8'h04);
      check(8'(irq_o), 8'h00);
      wr(pms_pkg::OFF_IRQ_MASK, 8'h04);
      @(posedge clock_i);
      check(8'(irq_o), 8'h01);
      wr(pms_pkg::OFF_IRQ_STAT, 8'h04);
      @(posedge clock_i);
      check(8'(irq_o), 8'h00);
      $display("idle done");
      // Power-down with each wake source, allowed and blocked
      for (int k = 0; k < 6; k++)
      begin
         wr(pms_pkg::OFF_PLL_CTRL, {3'h0, osc_t[k], 4'h0});
         wr(pms_pkg::OFF_PWR_CTRL, pc_t[k]);
         rd(pms_pkg::OFF_STATUS, rv);
         check(rv, 8'h08);
         check(8'({ctl_o.osc_en, ctl_o.tic_clk_en}), {6'h00, !osc_t[k], !osc_t[k]});
         check(8'({ctl_o.pll_en, ctl_o.periph_clk_en, ctl_o.dac_oe, ctl_o.port_hold, ctl_o.ale_force,
                   ctl_o.prog_store_strobe_force, ctl_o.strobe_level}), 8'h0e);
         w = wakes;
         fire[src_t[k]] <= 1'b1;
         @(posedge clock_i);
         fire <= 3'h0;
         if (k < 3)
            poll_lock(osc_t[k] ? PLL + XTAL : PLL);
         else
         begin
            repeat (12) @(posedge clock_i);
            reset_pin_i <= 1'b1;
            repeat (6) @(posedge clock_i);
            check(8'(chip_rst_o), 8'h01);
            reset_pin_i <= 1'b0;
            until_rst(1'b0, n);
            check(8'(n < 10), 8'h01);
         end
         check(8'(wakes - w), 8'(k < 3));
         rd(pms_pkg::OFF_PWR_CTRL, rv);
         check(rv, (k < 3) ? pc_t[k] & 8'h0c : 8'h00);
      end
      $display("power-down done");
      // Supply dips: mid-range keeps running, deep dip restarts with defaults
      wr(pms_pkg::OFF_PWR_CTRL, 8'h0c);
      vdd_mv_i <= 16'(pms_pkg::VDD_OFF_MV + 100 + $urandom % 1300);
      repeat (10) @(posedge clock_i);
      check(8'(chip_rst_o), 8'h00);
      vdd_mv_i <= 16'(pms_pkg::VDD_OFF_MV - 200);
      until_rst(1'b1, n);
      check(8'(chip_rst_o), 8'h01);
      vdd_mv_i <= 16'(pms_pkg::VDD_ON_MV + 50 + $urandom % 1000);
      until_rst(1'b0, n);
      check(8'(n >= POR && n <= POR + 8), 8'h01);
      rd(pms_pkg::OFF_PWR_CTRL, rv);
      check(rv, 8'h00);
      $display("supply done");
      wrap_up();
   end
endmodule : test_pms_sequencer
`default_nettype wire
